// [verilog/see_i2c_slave.sv]
// Purpose: Two-wire bus slave with select decode, page write, self-timed programming and reads.
// Assumes: The bus clock is slow against clk, and the storage array is made of flip-flops.
// Notes: Overview of operation
// Overview of operation
// - Data line captured on bus clock rising edges.
// - Type identifier 1010b needed in upper bits.
// - Chip address must equal strap inputs.
// - Eighth select bit: one read, zero write.
// - Match acknowledges; mismatch releases until next start.
// - Write select then two acknowledged address bytes.
// - Write protect blocks data acknowledge and writes.
// - Sixteen-bit address, high byte sent first.
// - Programming starts only on stop after data acknowledge.
// - Counter points past last modified byte afterwards.
// - Programming ignores bus and never acknowledges.
// - Busy ignores polling; acknowledges once finished.
// - Page write holds one to sixty-four bytes.
// - Acknowledge data, advance in-page counter each byte.
// - Six check bits correct single errors per word.
// - Any write rewrites whole word with check bits.
// - Reads ignore write protect; counter increments.
// - Random read: dummy write, repeated start, read.
// - Current read outputs counter byte then increments.
// - Master acknowledge continues with next address.
// - Sequential read wraps from top to zero.
// - Start is data falling while clock high.
// - Stop is data rising while clock high.
// - Master no-acknowledge ends read into standby.
`timescale 1ns/10ps

module see_fifo #(
   parameter int WIDTH = 46,
   parameter int DEPTH = 8
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic inValid,
   output logic inReady,
   input wire logic [WIDTH-1:0] inData,
   output logic outValid,
   input wire logic outReady,
   output logic [WIDTH-1:0] outData
);
   localparam int PTR_W = $clog2(DEPTH);
   logic [WIDTH-1:0] store [DEPTH];
   logic [PTR_W-1:0] wrPtr;
   logic [PTR_W-1:0] rdPtr;
   logic [PTR_W:0] count;
   logic push;
   logic pop;

   assign inReady = (count != (PTR_W+1)'(DEPTH));
   assign outValid = (count != '0);
   assign outData = store[rdPtr];
   assign push = inValid && inReady;
   assign pop = outValid && outReady;

   always_ff @(posedge clk) begin
      if (push) begin
         store[wrPtr] <= inData;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         wrPtr <= '0;
         rdPtr <= '0;
         count <= '0;
      end else begin
         if (push) begin
            wrPtr <= (wrPtr == PTR_W'(DEPTH - 1)) ? '0 : wrPtr + 1'b1;
         end
         if (pop) begin
            rdPtr <= (rdPtr == PTR_W'(DEPTH - 1)) ? '0 : rdPtr + 1'b1;
         end
         count <= count + (PTR_W+1)'(push) - (PTR_W+1)'(pop);
      end
   end
endmodule

module see_i2c_slave #(
   parameter int unsigned PROG_CYCLES = see_pkg::PROG_CYCLES,
   parameter int MEM_ADDR_W = see_pkg::MEM_ADDR_W
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic scl,
   input wire logic sdaIn,
   output logic sdaOut,
   output logic sdaOe,
   input wire logic chipAddrStrap0,
   input wire logic chipAddrStrap1,
   input wire logic chipAddrStrap2,
   input wire logic writeProtectInput,
   output logic progBusy
);
   localparam int MEM_WORDS = 1 << (MEM_ADDR_W - see_pkg::BYTE_SEL_W);
   localparam int PW = see_pkg::PAGE_W;
   localparam int AW = see_pkg::ADDR_W;
   // A stop can only be seen after the clock has risen once in the slot after a data ack.
   localparam logic [3:0] STOP_SLOT_CNT = 4'h1;

   // ----------------------------------------------------------------
   // Pin synchronisers and bus condition detection.
   // ----------------------------------------------------------------
   logic [5:0] pinMeta;
   logic [5:0] pinSync;
   logic sclDel;
   logic sdaDel;
   logic sclS;
   logic sdaS;
   logic wpS;
   logic [2:0] strapS;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         pinMeta <= 6'h03;
         pinSync <= 6'h03;
         sclDel <= 1'b1;
         sdaDel <= 1'b1;
      end else begin
         pinMeta <= {chipAddrStrap2, chipAddrStrap1, chipAddrStrap0, writeProtectInput, sdaIn,
                     scl};
         pinSync <= pinMeta;
         sclDel <= pinSync[0];
         sdaDel <= pinSync[1];
      end
   end

   assign sclS = pinSync[0];
   assign sdaS = pinSync[1];
   assign wpS = pinSync[2];
   assign strapS = pinSync[5:3];

   logic sclRise;
   logic sclFall;
   logic startEv;
   logic stopEv;
   assign sclRise = sclS && !sclDel;
   assign sclFall = !sclS && sclDel;
   assign startEv = sclS && sclDel && sdaDel && !sdaS;
   assign stopEv = sclS && sclDel && !sdaDel && sdaS;

   // ----------------------------------------------------------------
   // Shared state and combinational helpers.
   // ----------------------------------------------------------------
   see_pkg::see_state_t state;
   logic [3:0] bitCnt;
   logic [7:0] rxShift;
   logic [7:0] txShift;
   logic rwBit;
   logic masterAck;
   logic wpLatched;
   logic [AW-1:0] addrCnt;
   logic [7:0] addrHi;
   logic [AW-1:0] wAddr;
   logic [AW-1:0] lastAddr;
   logic [7:0] pageData [1 << PW];
   logic [(1 << PW)-1:0] pageValid;
   logic [31:0] progTimer;
   logic [4:0] seqWord;
   logic [see_pkg::CW_W:1] mem [MEM_WORDS];
   logic memReady;

   logic inBusy;
   logic byteDone;
   logic selMatch;
   logic progGo;
   logic progDone;
   logic loadRd;
   logic [31:0] rdWord;
   logic [7:0] rdByte;

   assign inBusy = (state == see_pkg::ST_PROG);
   assign byteDone = sclFall && (bitCnt == see_pkg::BITS_PER_BYTE);
   assign selMatch = (rxShift[7:4] == see_pkg::DEV_TYPE)
                     && (rxShift[3:1] == strapS);
   assign progGo = (state == see_pkg::ST_WDATA) && (bitCnt == STOP_SLOT_CNT)
                   && (|pageValid) && !wpLatched;
   assign progDone = inBusy && (progTimer == 32'(PROG_CYCLES - 1));
   assign loadRd = sclFall && (((state == see_pkg::ST_DEV_ACK) && rwBit)
                   || ((state == see_pkg::ST_RDATA_ACK) && masterAck));
   assign rdWord = see_pkg::eccDecode(mem[addrCnt[MEM_ADDR_W-1:see_pkg::BYTE_SEL_W]]);
   assign rdByte = rdWord[8*addrCnt[see_pkg::BYTE_SEL_W-1:0] +: 8];

   // ----------------------------------------------------------------
   // Protocol state machine, shifters and data line drive.
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state <= see_pkg::ST_IDLE;
         bitCnt <= see_pkg::BIT_CNT_ZERO;
         rxShift <= 8'h00;
         txShift <= 8'h00;
         rwBit <= 1'b0;
         masterAck <= 1'b0;
         sdaOe <= 1'b0;
         sdaOut <= 1'b0;
      end else if (inBusy) begin
         sdaOe <= 1'b0;
         if (progDone) begin
            state <= see_pkg::ST_IDLE;
         end
      end else if (stopEv) begin
         sdaOe <= 1'b0;
         state <= progGo ? see_pkg::ST_PROG : see_pkg::ST_IDLE;
      end else if (startEv) begin
         sdaOe <= 1'b0;
         bitCnt <= see_pkg::BIT_CNT_ZERO;
         state <= see_pkg::ST_DEV;
      end else begin
         if (sclRise && bitCnt != see_pkg::BITS_PER_BYTE) begin
            rxShift <= {rxShift[6:0], sdaS};
            bitCnt <= bitCnt + 4'h1;
         end
         unique case (state)
            see_pkg::ST_IDLE: begin
            end
            see_pkg::ST_DEV: begin
               if (byteDone) begin
                  if (selMatch) begin
                     sdaOe <= 1'b1;
                     rwBit <= rxShift[0];
                     state <= see_pkg::ST_DEV_ACK;
                  end else begin
                     state <= see_pkg::ST_IDLE;
                  end
               end
            end
            see_pkg::ST_DEV_ACK, see_pkg::ST_RDATA_ACK: begin
               if (sclRise && state == see_pkg::ST_RDATA_ACK) begin
                  masterAck <= !sdaS;
               end
               if (loadRd) begin
                  txShift <= rdByte;
                  sdaOe <= !rdByte[7];
                  bitCnt <= see_pkg::BIT_CNT_ZERO;
                  state <= see_pkg::ST_RDATA;
               end else if (sclFall) begin
                  sdaOe <= 1'b0;
                  bitCnt <= see_pkg::BIT_CNT_ZERO;
                  state <= rwBit ? see_pkg::ST_IDLE : see_pkg::ST_ADDRH;
               end
            end
            see_pkg::ST_ADDRH, see_pkg::ST_ADDRL: begin
               if (byteDone) begin
                  sdaOe <= 1'b1;
                  state <= (state == see_pkg::ST_ADDRH) ? see_pkg::ST_ADDRH_ACK
                                                        : see_pkg::ST_ADDRL_ACK;
               end
            end
            see_pkg::ST_ADDRH_ACK, see_pkg::ST_ADDRL_ACK, see_pkg::ST_WDATA_ACK: begin
               if (sclFall) begin
                  sdaOe <= 1'b0;
                  bitCnt <= see_pkg::BIT_CNT_ZERO;
                  state <= (state == see_pkg::ST_ADDRH_ACK) ? see_pkg::ST_ADDRL
                                                            : see_pkg::ST_WDATA;
               end
            end
            see_pkg::ST_WDATA: begin
               if (byteDone) begin
                  sdaOe <= !wpLatched;
                  state <= see_pkg::ST_WDATA_ACK;
               end
            end
            see_pkg::ST_RDATA: begin
               if (sclRise) begin
                  bitCnt <= bitCnt + 4'h1;
               end
               if (byteDone) begin
                  sdaOe <= 1'b0;
                  state <= see_pkg::ST_RDATA_ACK;
               end else if (sclFall) begin
                  txShift <= {txShift[6:0], 1'b0};
                  sdaOe <= !txShift[6];
               end
            end
            see_pkg::ST_PROG: begin
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Write protect capture from start through second address byte.
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         wpLatched <= 1'b0;
      end else if (startEv && !inBusy) begin
         wpLatched <= wpS;
      end else if (state == see_pkg::ST_DEV || state == see_pkg::ST_DEV_ACK
                   || state == see_pkg::ST_ADDRH || state == see_pkg::ST_ADDRH_ACK
                   || state == see_pkg::ST_ADDRL) begin
         wpLatched <= wpLatched | wpS;
      end
   end

   // ----------------------------------------------------------------
   // Address counter and page latch.
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         addrCnt <= '0;
         addrHi <= 8'h00;
         wAddr <= '0;
         lastAddr <= '0;
      end else if (progDone) begin
         addrCnt <= lastAddr + 1'b1;
      end else if (!inBusy && !startEv && !stopEv) begin
         if (byteDone && state == see_pkg::ST_ADDRH) begin
            addrHi <= rxShift;
         end
         if (byteDone && state == see_pkg::ST_ADDRL) begin
            addrCnt <= {addrHi, rxShift};
            wAddr <= {addrHi, rxShift};
         end
         if (byteDone && state == see_pkg::ST_WDATA && !wpLatched) begin
            lastAddr <= wAddr;
            wAddr[PW-1:0] <= wAddr[PW-1:0] + 1'b1;
         end
         if (loadRd) begin
            addrCnt <= addrCnt + 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (byteDone && state == see_pkg::ST_WDATA && !wpLatched && !inBusy) begin
         pageData[wAddr[PW-1:0]] <= rxShift;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         pageValid <= '0;
      end else if (progDone || (!inBusy && (startEv || (stopEv && !progGo)))) begin
         pageValid <= '0;
      end else if (byteDone && state == see_pkg::ST_WDATA && !wpLatched && !inBusy) begin
         pageValid[wAddr[PW-1:0]] <= 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // Programming cycle: timer and word merge sequencer.
   // ----------------------------------------------------------------
   logic [31:0] mergeData;
   logic [31:0] oldData;
   logic [3:0] wordValid;
   logic [PW-1:0] byteBase;
   logic seqActive;
   see_pkg::see_wr_t wrReq;
   logic fifoInReady;
   see_pkg::see_wr_t fifoOut;
   logic fifoOutValid;

   assign byteBase = {seqWord[3:0], 2'b00};
   assign oldData = see_pkg::eccDecode(mem[{wAddr[MEM_ADDR_W-1:PW], seqWord[3:0]}]);
   assign seqActive = inBusy && (seqWord < 5'(see_pkg::PAGE_WORDS));

   genvar gb;
   generate
      for (gb = 0; gb < 4; gb++) begin : g_merge
         assign wordValid[gb] = pageValid[byteBase + PW'(gb)];
         assign mergeData[8*gb +: 8] = wordValid[gb] ? pageData[byteBase + PW'(gb)]
                                                     : oldData[8*gb +: 8];
      end
   endgenerate

   assign wrReq.wordIdx = see_pkg::WORD_IDX_W'({wAddr[AW-1:PW], seqWord[3:0]});
   assign wrReq.data = mergeData;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         progTimer <= '0;
         seqWord <= '0;
         progBusy <= 1'b0;
      end else if (!inBusy) begin
         progTimer <= '0;
         seqWord <= '0;
         progBusy <= stopEv && progGo;
      end else begin
         progTimer <= progTimer + 32'h1;
         progBusy <= !progDone;
         if (seqActive && (!(|wordValid) || fifoInReady)) begin
            seqWord <= seqWord + 5'h1;
         end
      end
   end

   see_fifo #(
      .WIDTH($bits(see_pkg::see_wr_t)),
      .DEPTH(see_pkg::FIFO_DEPTH)
   ) u_fifo (
      .clk(clk),
      .rst_n(rst_n),
      .inValid(seqActive && (|wordValid)),
      .inReady(fifoInReady),
      .inData(wrReq),
      .outValid(fifoOutValid),
      .outReady(memReady),
      .outData(fifoOut)
   );

   // ----------------------------------------------------------------
   // Storage array with one word write every other cycle.
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         memReady <= 1'b0;
      end else begin
         memReady <= !memReady;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         for (int i = 0; i < MEM_WORDS; i++) begin
            mem[i] <= see_pkg::ERASED_CW;
         end
      end else if (fifoOutValid && memReady) begin
         mem[fifoOut.wordIdx[MEM_ADDR_W-3:0]] <= see_pkg::eccEncode(fifoOut.data);
      end
   end
endmodule

// [verilog/see_pkg.sv]
// Purpose: Shared constants, types and check-bit functions for the serial memory slave.
// Assumes: A 25 MHz system clock and a byte address of sixteen bits.
// Notes: Each stored word holds four data bytes and six check bits.
package see_pkg;

   // ----------------------------------------------------------------
   // Address and word layout.
   // ----------------------------------------------------------------
   localparam int ADDR_W = 16;
   localparam int PAGE_W = 6;
   localparam int BYTE_SEL_W = 2;
   localparam int WORD_IDX_W = ADDR_W - BYTE_SEL_W;
   localparam int PAGE_WORDS = 16;
   localparam int DATA_W = 32;
   localparam int CW_W = 38;
   localparam int MEM_ADDR_W = 14;
   localparam int FIFO_DEPTH = 8;

   // ----------------------------------------------------------------
   // Select byte fields and bit counting.
   // ----------------------------------------------------------------
   localparam logic [3:0] DEV_TYPE = 4'ha;
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;
   localparam logic [3:0] BIT_CNT_ZERO = 4'h0;

   // ----------------------------------------------------------------
   // Timing.
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 40;
   localparam int PROG_CYCLE_TIME_NS = 5000000;
   localparam int PROG_CYCLES = (PROG_CYCLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // ----------------------------------------------------------------
   // Protocol states.
   // ----------------------------------------------------------------
   typedef enum logic [11:0] {
      ST_IDLE = 12'h001,
      ST_DEV = 12'h002,
      ST_DEV_ACK = 12'h004,
      ST_ADDRH = 12'h008,
      ST_ADDRH_ACK = 12'h010,
      ST_ADDRL = 12'h020,
      ST_ADDRL_ACK = 12'h040,
      ST_WDATA = 12'h080,
      ST_WDATA_ACK = 12'h100,
      ST_RDATA = 12'h200,
      ST_RDATA_ACK = 12'h400,
      ST_PROG = 12'h800
   } see_state_t;

   typedef struct packed {
      logic [WORD_IDX_W-1:0] wordIdx;
      logic [DATA_W-1:0] data;
   } see_wr_t;

   // ----------------------------------------------------------------
   // Single error correcting code over one word.
   // ----------------------------------------------------------------
   function automatic logic [CW_W:1] eccEncode(input logic [DATA_W-1:0] d);
      logic [CW_W:1] c;
      int j;
      logic p;
      c = '0;
      j = 0;
      for (int i = 1; i <= CW_W; i++) begin
         if ((i & (i - 1)) != 0) begin
            c[i] = d[j];
            j++;
         end
      end
      for (int k = 0; k < 6; k++) begin
         p = 1'b0;
         for (int i = 1; i <= CW_W; i++) begin
            if ((((i >> k) & 1) == 1) && ((i & (i - 1)) != 0)) begin
               p = p ^ c[i];
            end
         end
         c[1 << k] = p;
      end
      return c;
   endfunction

   function automatic logic [DATA_W-1:0] eccDecode(input logic [CW_W:1] cw);
      logic [CW_W:1] c;
      logic [5:0] syn;
      logic [DATA_W-1:0] d;
      int j;
      c = cw;
      syn = 6'h00;
      d = '0;
      j = 0;
      for (int i = 1; i <= CW_W; i++) begin
         if (c[i]) begin
            syn = syn ^ 6'(i);
         end
      end
      if (syn != 6'h00 && int'(syn) <= CW_W) begin
         c[syn] = ~c[syn];
      end
      for (int i = 1; i <= CW_W; i++) begin
         if ((i & (i - 1)) != 0) begin
            d[j] = c[i];
            j++;
         end
      end
      return d;
   endfunction

   localparam logic [CW_W:1] ERASED_CW = eccEncode(32'hffffffff);

endpackage

// [sim/see_i2c_slave_asserts.sv]
// Purpose: Concurrent checks on the serial memory slave pins.
// Assumes: Bus clock phases of four or more system clocks.
// Notes: Bound to the slave from the bench top file.
`timescale 1ns/10ps
module see_i2c_slave_asserts #(
   parameter int unsigned PROG_CYCLES = 64,
   parameter int MEM_ADDR_W = 8
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic scl,
   input wire logic sdaIn,
   input wire logic sdaOut,
   input wire logic sdaOe,
   input wire logic chipAddrStrap0,
   input wire logic chipAddrStrap1,
   input wire logic chipAddrStrap2,
   input wire logic writeProtectInput,
   input wire logic progBusy
);
   // ----------------------------------------------------------------
   // Pin event helpers.
   // ----------------------------------------------------------------
   logic sclQ;
   logic sdaQ;
   logic wpAll;
   logic [7:0] stopAge;
   int unsigned busyCnt;
   wire logic stopEv = sclQ && scl && !sdaQ && sdaIn;
   wire logic startEv = sclQ && scl && sdaQ && !sdaIn;
   always_ff @(posedge clk) begin
      sclQ <= scl;
      sdaQ <= sdaIn;
   end
   always_ff @(posedge clk) begin
      if (!rst_n || !progBusy) busyCnt <= 0;
      else busyCnt <= busyCnt + 1;
   end
   always_ff @(posedge clk) begin
      if (!rst_n) stopAge <= 8'hff;
      else if (stopEv) stopAge <= 8'h00;
      else if (stopAge != 8'hff) stopAge <= stopAge + 8'h01;
   end
   always_ff @(posedge clk) begin
      if (!rst_n) wpAll <= 1'b0;
      else if (startEv) wpAll <= writeProtectInput;
      else if (!writeProtectInput) wpAll <= 1'b0;
   end
   // ----------------------------------------------------------------
   // Properties.
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   property p_busy_quiet;
      progBusy |-> !sdaOe;
   endproperty
   a_busy_quiet: assert property (p_busy_quiet) else $error("data driven while busy");
   property p_open_drain;
      sdaOe |-> !sdaOut;
   endproperty
   a_open_drain: assert property (p_open_drain) else $error("data driven high");
   property p_busy_len;
      $fell(progBusy) |-> busyCnt == PROG_CYCLES;
   endproperty
   a_busy_len: assert property (p_busy_len) else $error("busy length wrong");
   property p_busy_cause;
      $rose(progBusy) |-> stopAge < 8'h08;
   endproperty
   a_busy_cause: assert property (p_busy_cause) else $error("busy without stop");
   property p_oe_low_phase;
      $changed(sdaOe) |-> !scl;
   endproperty
   a_oe_low_phase: assert property (p_oe_low_phase) else $error("drive moved, clock high");
   property p_wp_no_prog;
      $rose(progBusy) |-> !wpAll;
   endproperty
   a_wp_no_prog: assert property (p_wp_no_prog) else $error("programmed while protected");
   property p_oe_stands;
      $rose(sdaOe) |-> sdaOe [*6];
   endproperty
   a_oe_stands: assert property (p_oe_stands) else $error("drive too short");
   property p_stop_quiet;
      stopEv |-> !sdaOe [*8];
   endproperty
   a_stop_quiet: assert property (p_stop_quiet) else $error("drive after stop");
   property p_start_quiet;
      startEv |-> !sdaOe [*8];
   endproperty
   a_start_quiet: assert property (p_start_quiet) else $error("drive after start");
endmodule

// [sim/see_master.sv]
// Purpose: Behavioural two-wire bus master facing the slave.
// Assumes: One bus bit takes eight system clocks.
// Notes: Each byte task reports its result through res and done.
`timescale 1ns/10ps
module see_master (
   input wire logic clk,
   output logic scl,
   output logic sdaDrv,
   input wire logic sdaWire
);
   logic [7:0] res;
   event done;
   initial begin
      scl = 1'b1;
      sdaDrv = 1'b1;
   end
   task automatic tick(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic bitIo(input logic b, output logic r);
      tick(2);
      sdaDrv = b;
      tick(2);
      scl = 1'b1;
      tick(4);
      r = sdaWire;
      scl = 1'b0;
   endtask
   task automatic start();
      sdaDrv = 1'b1;
      tick(4);
      scl = 1'b1;
      tick(4);
      sdaDrv = 1'b0;
      tick(4);
      scl = 1'b0;
   endtask
   task automatic stop();
      tick(2);
      sdaDrv = 1'b0;
      tick(2);
      scl = 1'b1;
      tick(4);
      sdaDrv = 1'b1;
      tick(4);
   endtask
   task automatic wrByte(input logic [7:0] b);
      logic r;
      for (int i = 7; i >= 0; i--) bitIo(b[i], r);
      bitIo(1'b1, r);
      res = {7'h00, !r};
      -> done;
   endtask
   task automatic rdByte(input logic ack);
      logic r;
      logic [7:0] d;
      for (int i = 7; i >= 0; i--) begin
         bitIo(1'b1, r);
         d[i] = r;
      end
      bitIo(!ack, r);
      res = d;
      -> done;
   endtask
endmodule

// [sim/see_i2c_slave_bench.sv]
// Purpose: Self-checking bench for the serial memory slave.
// Assumes: Straps at 010b then 101b, and a reduced array and busy time.
// Notes: Expected results queue up ahead of each bus byte.
`timescale 1ns/10ps
module see_i2c_slave_bench;
   localparam logic [7:0] SEL_W = 8'haa;
   localparam logic [7:0] SEL_R = 8'hab;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic wp = 1'b0;
   logic [2:0] strap = 3'b101;
   wire logic scl;
   wire logic sdaDrv;
   wire logic sdaOut;
   wire logic sdaOe;
   wire logic progBusy;
   wire logic sdaW = sdaDrv && !(sdaOe && !sdaOut);
   int err_total = 0;
   int compares = 0;
   int cyc = 0;
   logic [7:0] expQ[$];
   logic [7:0] mem[256];
   logic [31:0] lfsr = 32'h5271;
   initial forever #20 clk = ~clk;
   see_master see_master_i (.clk(clk), .scl(scl), .sdaDrv(sdaDrv), .sdaWire(sdaW));
   see_i2c_slave #(.PROG_CYCLES(200), .MEM_ADDR_W(8)) see_i2c_slave_i (
      .clk(clk), .rst_n(rst_n), .scl(scl), .sdaIn(sdaW), .sdaOut(sdaOut), .sdaOe(sdaOe),
      .chipAddrStrap0(strap[0]), .chipAddrStrap1(strap[1]), .chipAddrStrap2(strap[2]),
      .writeProtectInput(wp), .progBusy(progBusy));
   // ----------------------------------------------------------------
   // Checking and bus sequence tasks.
   // ----------------------------------------------------------------
   function automatic logic [31:0] lfsrNext(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic final_report();
      $display("compares %0d errors %0d", compares, err_total);
      if (err_total == 0 && compares > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wb(input logic [7:0] b, input logic a);
      expQ.push_back({7'h00, a});
      see_master_i.wrByte(b);
   endtask
   task automatic waitIdle();
      for (int n = 0; n < 1000 && progBusy !== 1'b0; n++) @(negedge clk);
      chk("idle", {7'h00, progBusy}, 8'h00);
   endtask
   task automatic setAddr(input logic [15:0] a);
      see_master_i.start();
      wb(SEL_W, 1'b1);
      wb(a[15:8], 1'b1);
      wb(a[7:0], 1'b1);
   endtask
   task automatic pageWr(input logic [15:0] a, input int n);
      logic [7:0] d;
      setAddr(a);
      for (int i = 0; i < n; i++) begin
         d = lfsr[7:0];
         lfsr = lfsrNext(lfsr);
         wb(d, !wp);
         if (!wp) mem[{a[7:6], 6'(a[5:0] + i)}] = d;
      end
      see_master_i.stop();
      see_master_i.tick(8);
      chk("busy", {7'h00, progBusy}, {7'h00, n > 0 && !wp});
      if (n > 0 && !wp) begin
         see_master_i.start();
         wb(SEL_W, 1'b0);
         see_master_i.stop();
      end
      waitIdle();
   endtask
   task automatic curRd(input logic [7:0] a, input int n);
      see_master_i.start();
      wb(SEL_R, 1'b1);
      for (int i = 0; i < n; i++) begin
         expQ.push_back(mem[8'(a + i)]);
         see_master_i.rdByte(i != n - 1);
      end
      see_master_i.stop();
   endtask
   task automatic rdSeq(input logic [15:0] a, input int n);
      setAddr(a);
      curRd(a[7:0], n);
   endtask
   // ----------------------------------------------------------------
   // Result watcher, timeout and main sequence.
   // ----------------------------------------------------------------
   initial forever begin
      @(see_master_i.done);
      chk("bus result", see_master_i.res, expQ.pop_front());
   end
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         err_total++;
         final_report();
      end
   end
   initial begin
      foreach (mem[i]) mem[i] = 8'hff;
      repeat (8) @(negedge clk);
      rst_n = 1'b1;
      see_master_i.tick(4);
      for (int s = 0; s < 2; s++) begin
         strap = (s == 0) ? 3'b010 : 3'b101;
         for (int c = 0; c < 8; c++) begin
            see_master_i.start();
            wb({4'ha, 3'(c), 1'b0}, 3'(c) == strap);
            see_master_i.stop();
         end
      end
      see_master_i.start();
      wb(8'hba, 1'b0);
      see_master_i.stop();
      pageWr(16'h0010, 0);
      pageWr(16'h003e, 5);
      rdSeq(16'h003e, 3);
      rdSeq(16'h0000, 4);
      pageWr(16'h0081, 1);
      pageWr(16'h0080, 1);
      curRd(8'h81, 2);
      curRd(8'h83, 1);
      wp = 1'b1;
      pageWr(16'h0081, 2);
      rdSeq(16'h0080, 3);
      wp = 1'b0;
      rdSeq(16'hffff, 2);
      see_master_i.tick(20);
      final_report();
   end
endmodule
bind see_i2c_slave see_i2c_slave_asserts #(.PROG_CYCLES(PROG_CYCLES), .MEM_ADDR_W(MEM_ADDR_W))
   see_i2c_slave_asserts_i (.clk(clk), .rst_n(rst_n), .scl(scl), .sdaIn(sdaIn),
   .sdaOut(sdaOut), .sdaOe(sdaOe), .chipAddrStrap0(chipAddrStrap0),
   .chipAddrStrap1(chipAddrStrap1), .chipAddrStrap2(chipAddrStrap2),
   .writeProtectInput(writeProtectInput), .progBusy(progBusy));
